// [hdl/gap_port.sv]
// four-bit port with address outputs and a classic wishbone register slave
//
// What this block does
// RULE1 - unclaimed pin: direction 1 makes port output, 0 makes port input
// RULE2 - direction register is write-only; reads give no stored bits
// RULE3 - register bits 7 to 4 ignore writes
// RULE4 - settings clear on reset or hw standby, hold in software standby
// RULE5 - in software standby, hold bit picks drive or float for address pins
// RULE6 - modes 4 to 6: enabled address pins drive address over direction
// RULE7 - readback gives latch where direction is 1, pin level where 0
// RULE8 - readback register ignores writes; outputs go through the latch
// RULE9 - readback follows pins after reset, holds through software standby
// RULE10 - pull-up on only for direction 0 with pull-up select 1
// RULE11 - pull-up off on address or port outputs, reset and hardware standby
// RULE12 - port output with drain bit 1 drives low only, else push-pull
// RULE13 - modes 4 to 6: bit three drives address 19 when field is 11xx
// RULE14 - modes 4 to 6: bit two drives address 18 for 1011 or 11xx
// RULE15 - modes 4 to 6: bit one drives address 17 for 101x or 11xx
// RULE16 - modes 4 to 6: bit zero drives address 16 unless 0xxx or 1000
// RULE17 - mode 7: no address pins, direction bits alone decide
// RULE18 - reserved and unreadable bits read as zero
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module gap_port
  import gap_pkg::*;
#(
  parameter int ADR_W = 18
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave, byte addressed
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [BUS_W-1:0] wb_dat_i,
  output logic [BUS_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // chip-level controls
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  input wire logic standby_output_hold_i,
  input wire logic [2:0] op_mode_i,
  input wire logic [3:0] address_enable_field_i,
  input wire logic [3:0] address_hi_i,
  // pins
  input wire logic [3:0] pin_in_i,
  output logic [3:0] pin_out_o,
  output logic [3:0] pin_oe_o,
  output logic [3:0] pullup_en_o
);

  // the index must fit above the two dropped byte bits
  generate
    if (ADR_W < 16 + IDX_SHIFT) begin : g_bad_adr
      $error("gap_port: ADR_W too small for the register indices");
    end
  endgenerate

  // whole state of the block
  typedef struct packed {
    logic [3:0] pin_direction;
    logic [3:0] output_latch;
    logic [3:0] pullup_select;
    logic [3:0] drain_mode_select;
    logic [3:0] pin_state_readback;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] pullup_en;
    logic [7:0] rd_data;
    logic ack;
  } gap_state_t;

  gap_state_t st_r;
  gap_state_t st_nxt;

  gap_pad_if pif ();

  logic [15:0] idx;
  logic req;
  logic wr_lane;

  // register index from a byte address
  function automatic logic [15:0] gap_index(input logic [ADR_W-1:0] a);
    gap_index = a[IDX_SHIFT +: 16];
  endfunction

  // widen a four-bit field into the low byte, upper bits as fill
  function automatic logic [7:0] gap_byte(input logic [3:0] v);
    gap_byte = {READ_FILL[7:4], v}; // see RULE18
  endfunction

  // helper blocks
  gap_addr_claim u_claim (
    .c (pif.dec)
  );

  gap_pad_ctl u_pad (
    .p (pif.pad)
  );

  // inputs of the helpers come from state and controls
  always_comb begin
    pif.mode = gap_mode_t'(op_mode_i);
    pif.ae = address_enable_field_i;
    pif.dir = st_r.pin_direction;
    pif.latch = st_r.output_latch;
    pif.pull = st_r.pullup_select;
    pif.odr = st_r.drain_mode_select;
    pif.addr = address_hi_i;
    pif.hold = standby_output_hold_i;
    pif.sw_sby = sw_standby_i;
    pif.hw_sby = hw_standby_i;
  end

  // bus request decode; a request is taken once, ack closes it
  always_comb begin
    idx = gap_index(wb_adr_i);
    req = wb_cyc_i & wb_stb_i & ~st_r.ack;
    wr_lane = req & wb_we_i & wb_sel_i[0];
  end

  // next-state logic for registers, readback, pins and bus answer
  always_comb begin
    st_nxt = st_r;

    // ack for exactly one cycle per request, unmapped included
    st_nxt.ack = req;

    // register writes; only bits 3 to 0 are stored
    if (wr_lane) begin
      case (idx)
        IDX_PIN_DIRECTION: begin
          st_nxt.pin_direction = wb_dat_i[3:0]; // see RULE3
        end
        IDX_OUTPUT_LATCH: begin
          st_nxt.output_latch = wb_dat_i[3:0]; // see RULE3
        end
        IDX_PULLUP_SELECT: begin
          st_nxt.pullup_select = wb_dat_i[3:0];
        end
        IDX_DRAIN_MODE_SELECT: begin
          st_nxt.drain_mode_select = wb_dat_i[3:0];
        end
        default: begin
          // readback and unmapped addresses drop the write
          st_nxt.ack = req; // see RULE8
        end
      endcase
    end

    // read data, captured with the request
    if (req) begin
      case (idx)
        IDX_PIN_DIRECTION: begin
          st_nxt.rd_data = READ_FILL; // see RULE2
        end
        IDX_OUTPUT_LATCH: begin
          st_nxt.rd_data = gap_byte(st_r.output_latch);
        end
        IDX_PULLUP_SELECT: begin
          st_nxt.rd_data = gap_byte(st_r.pullup_select);
        end
        IDX_DRAIN_MODE_SELECT: begin
          st_nxt.rd_data = gap_byte(st_r.drain_mode_select);
        end
        IDX_PIN_STATE_READBACK: begin
          st_nxt.rd_data = gap_byte(st_r.pin_state_readback);
        end
        default: begin
          st_nxt.rd_data = READ_FILL;
        end
      endcase
    end else begin
      st_nxt.rd_data = READ_FILL;
    end

    // readback: latch on outputs, pins on inputs; frozen in software standby
    if (!sw_standby_i) begin
      st_nxt.pin_state_readback =
        (st_r.pin_direction & st_r.output_latch) |
        (~st_r.pin_direction & pin_in_i); // see RULE7
    end

    // pins registered so every output leaves a flip-flop
    st_nxt.pin_out = pif.out;
    st_nxt.pin_oe = pif.oe;
    st_nxt.pullup_en = pif.pu; // see RULE11

    // hardware standby clears settings like a reset but keeps bus alive
    if (hw_standby_i) begin
      st_nxt.pin_direction = RST_PIN_DIRECTION; // see RULE4
      st_nxt.output_latch = RST_OUTPUT_LATCH; // see RULE4
      st_nxt.pullup_select = RST_PULLUP_SELECT; // see RULE4
      st_nxt.drain_mode_select = RST_DRAIN_MODE_SELECT; // see RULE4
      st_nxt.pin_state_readback = pin_in_i; // see RULE9
      st_nxt.pullup_en = 4'h0; // see RULE11
    end
  end

  // single state register; software standby has no branch here, only the readback field holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.pin_direction <= RST_PIN_DIRECTION; // see RULE4
      st_r.output_latch <= RST_OUTPUT_LATCH;
      st_r.pullup_select <= RST_PULLUP_SELECT;
      st_r.drain_mode_select <= RST_DRAIN_MODE_SELECT;
      st_r.pin_state_readback <= RST_PIN_STATE_READBACK;
      st_r.pin_out <= 4'h0;
      st_r.pin_oe <= 4'h0;
      st_r.pullup_en <= 4'h0; // see RULE11
      st_r.rd_data <= READ_FILL;
      st_r.ack <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = {{(BUS_W-DATA_W){1'b0}}, st_r.rd_data};
  assign wb_ack_o = st_r.ack;
  assign pin_out_o = st_r.pin_out;
  assign pin_oe_o = st_r.pin_oe;
  assign pullup_en_o = st_r.pullup_en;

endmodule
`default_nettype wire

// [hdl/gap_pkg.sv]
// shared constants and types for the four-bit port with address outputs
package gap_pkg;

  // port geometry
  localparam int PORT_W = 4;
  localparam int DATA_W = 8;
  localparam int BUS_W = 32;

  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_PIN_DIRECTION = 16'hfe39;
  localparam logic [15:0] IDX_PULLUP_SELECT = 16'hfe40;
  localparam logic [15:0] IDX_DRAIN_MODE_SELECT = 16'hfe47;
  localparam logic [15:0] IDX_OUTPUT_LATCH = 16'hff09;
  localparam logic [15:0] IDX_PIN_STATE_READBACK = 16'hffb9;

  // byte-address bits dropped to form the index
  localparam int IDX_SHIFT = 2;

  // values after reset, and after hardware standby for all but the readback
  localparam logic [3:0] RST_PIN_DIRECTION = 4'h0;
  localparam logic [3:0] RST_PULLUP_SELECT = 4'h0;
  localparam logic [3:0] RST_DRAIN_MODE_SELECT = 4'h0;
  localparam logic [3:0] RST_OUTPUT_LATCH = 4'h0;
  localparam logic [3:0] RST_PIN_STATE_READBACK = 4'h0;

  // reserved upper register bits and unreadable registers read this
  localparam logic [7:0] READ_FILL = 8'h00;

  // operating modes
  typedef enum logic [2:0] {
    GAP_MODE_0 = 3'b000,
    GAP_MODE_1 = 3'b001,
    GAP_MODE_2 = 3'b010,
    GAP_MODE_3 = 3'b011,
    GAP_MODE_4 = 3'b100,
    GAP_MODE_5 = 3'b101,
    GAP_MODE_6 = 3'b110,
    GAP_MODE_7 = 3'b111
  } gap_mode_t;

endpackage

// [hdl/gap_pad_if.sv]
// signals shared between the port top and its two helper blocks
`timescale 1ns/1ps
`default_nettype none
interface gap_pad_if;
  import gap_pkg::*;
  gap_mode_t mode;
  logic [3:0] ae;
  logic [3:0] claim;
  logic [3:0] dir;
  logic [3:0] latch;
  logic [3:0] pull;
  logic [3:0] odr;
  logic [3:0] addr;
  logic hold;
  logic sw_sby;
  logic hw_sby;
  logic [3:0] out;
  logic [3:0] oe;
  logic [3:0] pu;
  modport dec (input mode, ae, output claim);
  modport pad (input claim, dir, latch, pull, odr, addr, hold, sw_sby, hw_sby,
    output out, oe, pu);
  modport top (output mode, ae, dir, latch, pull, odr, addr, hold, sw_sby,
    hw_sby, input claim, out, oe, pu);
endinterface
`default_nettype wire

// [hdl/gap_addr_claim.sv]
// decides which port pins are taken over as address outputs
`timescale 1ns/1ps
`default_nettype none
module gap_addr_claim
  import gap_pkg::*;
(
  gap_pad_if.dec c
);
  logic ext_mode;

  // only the external-address modes may hand pins to the bus
  always_comb begin
    case (c.mode)
      GAP_MODE_4, GAP_MODE_5, GAP_MODE_6: begin
        ext_mode = 1'b1; // see RULE6
      end
      default: begin
        ext_mode = 1'b0; // see RULE17
      end
    endcase
  end

  // per-pin address-enable decode
  always_comb begin
    c.claim[3] = ext_mode & (c.ae[3:2] == 2'b11); // see RULE13
    c.claim[2] = ext_mode &
      ((c.ae == 4'hb) | (c.ae[3:2] == 2'b11)); // see RULE14
    c.claim[1] = ext_mode &
      ((c.ae[3:1] == 3'b101) | (c.ae[3:2] == 2'b11)); // see RULE15
    c.claim[0] = ext_mode & c.ae[3] & (c.ae != 4'h8); // see RULE16
  end
endmodule
`default_nettype wire

// [hdl/gap_pad_ctl.sv]
// works out level, enable and pull-up for each pin
`timescale 1ns/1ps
`default_nettype none
module gap_pad_ctl
  import gap_pkg::*;
(
  gap_pad_if.pad p
);
  // address pins win over the direction bit; open drain only pulls low
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (p.hw_sby) begin
        p.out[i] = 1'b0;
        p.oe[i] = 1'b0;
      end else if (p.claim[i]) begin
        p.out[i] = p.addr[i]; // see RULE6
        p.oe[i] = ~p.sw_sby | p.hold; // see RULE5
      end else if (p.dir[i]) begin
        p.out[i] = p.odr[i] ? 1'b0 : p.latch[i]; // see RULE12
        p.oe[i] = p.odr[i] ? ~p.latch[i] : 1'b1; // see RULE1
      end else begin
        p.out[i] = 1'b0;
        p.oe[i] = 1'b0; // see RULE1
      end
      // pull-up only on real port inputs
      p.pu[i] = ~p.hw_sby & ~p.claim[i] & ~p.dir[i] & p.pull[i]; // see RULE10
    end
  end
endmodule
`default_nettype wire

// [testbench/gap_port_checker.sv]
// bus and pin assertions for the four-bit port
`timescale 1ns/1ps
`default_nettype none
module gap_port_checker
  import gap_pkg::*;
#(
  parameter int ADR_W = 18
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [BUS_W-1:0] wb_dat_i,
  input wire logic [BUS_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  input wire logic standby_output_hold_i,
  input wire logic [2:0] op_mode_i,
  input wire logic [3:0] address_enable_field_i,
  input wire logic [3:0] address_hi_i,
  input wire logic [3:0] pin_in_i,
  input wire logic [3:0] pin_out_o,
  input wire logic [3:0] pin_oe_o,
  input wire logic [3:0] pullup_en_o
);
  localparam logic [ADR_W-1:0] DIR_A = ADR_W'({IDX_PIN_DIRECTION, 2'b00});
  logic [3:0] ae;
  logic [3:0] clm;
  // pins taken as address lines, only in modes 4 to 6
  assign ae = address_enable_field_i;
  assign clm = (op_mode_i[2] && op_mode_i != 3'h7) ? {ae[3] & ae[2],
    ae[3] & (ae[2] | (ae[1] & ae[0])), ae[3] & (ae[2] | ae[1]),
    ae[3] & (ae[2:0] != 3'h0)} : 4'h0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_upper_zero; wb_ack_o |-> wb_dat_o[31:4] == 28'h0; endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits set");
  property p_dir_read; wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
    wb_adr_i == DIR_A |=> wb_dat_o == 32'h0; endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction readable");
  property p_claim_drive; !hw_standby_i && !sw_standby_i |=>
    (pin_oe_o & $past(clm)) == $past(clm) &&
    ((pin_out_o ^ $past(address_hi_i)) & $past(clm)) == 4'h0; endproperty
  a_claim_drive: assert property (p_claim_drive)
    else $error("address pin not driven");
  property p_sby_float; sw_standby_i && !hw_standby_i |=> (pin_oe_o &
    $past(clm)) == ($past(clm) & {4{$past(standby_output_hold_i)}});
  endproperty
  a_sby_float: assert property (p_sby_float)
    else $error("standby address drive wrong");
  property p_pull_oe; 1'b1 |=> (pullup_en_o & (pin_oe_o | $past(clm))) ==
    4'h0; endproperty
  a_pull_oe: assert property (p_pull_oe)
    else $error("pull-up on driven pin");
  property p_hw_sby; hw_standby_i |=> pin_oe_o == 4'h0 &&
    pullup_en_o == 4'h0; endproperty
  a_hw_sby: assert property (p_hw_sby)
    else $error("pins active in hw standby");
endmodule
bind gap_port gap_port_checker #(.ADR_W(ADR_W)) chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .hw_standby_i(hw_standby_i), .sw_standby_i(sw_standby_i),
  .standby_output_hold_i(standby_output_hold_i), .op_mode_i(op_mode_i),
  .address_enable_field_i(address_enable_field_i),
  .address_hi_i(address_hi_i), .pin_in_i(pin_in_i),
  .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o));
`default_nettype wire

// [testbench/gap_pin_model.sv]
// external pin loads: outside drivers, pull-ups, floating lines
`timescale 1ns/1ps
`default_nettype none
module gap_pin_model (
  input wire logic clk_i,
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  input wire logic [3:0] pu_i,
  input wire logic [3:0] ext_i,
  input wire logic [3:0] ext_en_i,
  output logic [3:0] pin_o
);
  logic [3:0] flt_r = 4'h5;
  // an undriven line without pull-up wanders, never holds a value
  always @(posedge clk_i) begin
    flt_r <= ~flt_r;
  end
  // open-drain high is just a released line
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i) |
    (~oe_i & ~ext_en_i & (pu_i | flt_r));
endmodule
`default_nettype wire

// [testbench/gap_port_tb.sv]
// random and corner tests of the four-bit port
`timescale 1ns/1ps
`default_nettype none
module four_bit_port_with_address_outputs_tb_top;
  import gap_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic hw = 0, sw = 0, hold = 0;
  logic [3:0] sel = 4'hf;
  logic [17:0] adr = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [2:0] mode = 3'h7;
  logic [3:0] ae = 0, ahi = 0, ext = 0, xen = 4'hf, pin, p_out, p_oe, p_pu;
  logic [3:0] d, l, pu, od, x, c, oe_e, out_e, lv, rb;
  logic [15:0] ra[5] = '{IDX_PIN_DIRECTION, IDX_PULLUP_SELECT,
    IDX_DRAIN_MODE_SELECT, IDX_OUTPUT_LATCH, 16'h1234};
  int fails = 0, check_count = 0, s0;
  always #5 clk_i = ~clk_i;
  gap_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .hw_standby_i(hw),
    .sw_standby_i(sw), .standby_output_hold_i(hold), .op_mode_i(mode),
    .address_enable_field_i(ae), .address_hi_i(ahi), .pin_in_i(pin),
    .pin_out_o(p_out), .pin_oe_o(p_oe), .pullup_en_o(p_pu));
  gap_pin_model pm_u (.clk_i(clk_i), .out_i(p_out), .oe_i(p_oe),
    .pu_i(p_pu), .ext_i(ext), .ext_en_i(xen), .pin_o(pin));
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // one classic cycle, held until ack is seen
  task automatic bus(input logic w, input logic [15:0] i,
    input logic [31:0] v);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= v;
    do @(posedge clk_i); while (ack !== 1'b1 && n++ < 50);
    if (n >= 50) fails++;
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  // written as a table on purpose, unlike the checker's equations
  function automatic logic [3:0] claim(input logic [2:0] m,
    input logic [3:0] f);
    if (m == 3'h7 || !m[2]) return 4'h0;
    casez (f)
      4'b11??: return 4'hf;
      4'b1011: return 4'h7;
      4'b1010: return 4'h3;
      4'b1001: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction
  task automatic finish_test;
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    s0 = $urandom(32'h95b0);
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    foreach (ra[k]) begin
      bus(0, ra[k], 0);
      chk("rst_val", q, 0);
    end
    bus(1, IDX_OUTPUT_LATCH, 32'hf5);
    bus(1, IDX_PIN_STATE_READBACK, 32'ha);
    // low byte lane off: the write is acked but dropped
    sel <= 4'he;
    bus(1, IDX_OUTPUT_LATCH, 32'h3);
    sel <= 4'hf;
    bus(0, IDX_OUTPUT_LATCH, 0);
    chk("latch", q, 32'h5);
    // every address-enable code, modes 4 to 6 for the first 16 passes then random mode, random pin settings
    for (int i = 0; i < 48; i++) begin
      {d, l, pu, od} = 16'($urandom);
      x = 4'($urandom);
      pu = pu | ~x;
      xen <= x;
      mode <= (i < 16) ? 3'(4 + i % 3) : 3'($urandom);
      ae <= i[3:0];
      ahi <= 4'($urandom);
      ext <= 4'($urandom);
      bus(1, IDX_PIN_DIRECTION, {28'($urandom), d});
      bus(1, IDX_OUTPUT_LATCH, {28'($urandom), l});
      bus(1, IDX_PULLUP_SELECT, {28'($urandom), pu});
      bus(1, IDX_DRAIN_MODE_SELECT, {28'($urandom), od});
      repeat (3) @(posedge clk_i);
      c = claim(mode, ae);
      oe_e = c | (~c & d & (~od | ~l));
      out_e = (c & ahi) | (~c & d & ~od & l);
      chk("oe", p_oe, oe_e);
      chk("out", p_out & oe_e, out_e);
      chk("pullup", p_pu, ~c & ~d & pu);
      bus(0, IDX_PIN_DIRECTION, 0);
      chk("dir_rd", q, 0);
      bus(0, IDX_PULLUP_SELECT, 0);
      chk("pull_rd", q, {28'h0, pu});
      bus(0, IDX_DRAIN_MODE_SELECT, 0);
      chk("drain_rd", q, {28'h0, od});
      lv = (oe_e & out_e) | (~oe_e & xen & ext) | (~oe_e & ~xen);
      bus(0, IDX_PIN_STATE_READBACK, 0);
      chk("readback", q, {28'h0, (d & l) | (~d & lv)});
    end
    // software standby: readback frozen, address pins float or hold
    rb = q[3:0];
    sw <= 1;
    for (int h = 0; h < 2; h++) begin
      @(posedge clk_i);
      hold <= h[0];
      ext <= ~ext;
      mode <= 3'h4;
      ae <= 4'hf;
      repeat (3) @(posedge clk_i);
      chk("sby_oe", p_oe, h[0] ? 4'hf : 4'h0);
      bus(0, IDX_PIN_STATE_READBACK, 0);
      chk("sby_rb", q, {28'h0, rb});
    end
    @(posedge clk_i);
    sw <= 0;
    hw <= 1;
    repeat (2) @(posedge clk_i);
    hw <= 0;
    foreach (ra[k]) begin
      bus(0, ra[k], 0);
      chk("hw_sby", q, 0);
    end
    // settings cleared, so every pin reads back its address level
    bus(0, IDX_PIN_STATE_READBACK, 0);
    chk("hw_rb", q, {28'h0, ahi});
    finish_test();
  end
  // hang guard, far beyond the 1400 or so cycles needed
  initial begin
    #200000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
